// ==== shared/mmd_pkg.sv ====
// Purpose: constants and carriers for the memory map and dual pointer block
// Assumes: single cpu clock, asynchronous active-low reset
// Notes: register offsets are special function register addresses
package mmd_pkg;
    localparam logic [7:0] OFS_DP0_LOW = 8'h82;
    localparam logic [7:0] OFS_DP0_HIGH = 8'h83;
    localparam logic [7:0] OFS_DP1_LOW = 8'h84;
    localparam logic [7:0] OFS_DP1_HIGH = 8'h85;
    localparam logic [7:0] OFS_PTR_SEL = 8'h86;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_PTR = 16'h0000;
    localparam logic [7:0] IRAM_UPPER_BASE = 8'h80;
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    localparam int BIT_AREA_BYTES = 16;
    localparam int CODE_BYTES = 16384;
    localparam logic [15:0] CODE_LAST = 16'h3fff;
    localparam int AUX_BYTES = 320;
    localparam int AUX_LOW_BYTES = 256;
    localparam int IRAM_BYTES = 256;
    localparam int AUX_EN_BIT = 4;
    localparam int BANK_HI_BIT = 4;
    localparam int BANK_LO_BIT = 3;
    localparam int SEL_BIT = 0;

    typedef enum logic [6:0] {
        MMD_OP_NONE = 7'h01,
        MMD_OP_INC = 7'h02,
        MMD_OP_LOAD = 7'h04,
        MMD_OP_CODE = 7'h08,
        MMD_OP_XRD = 7'h10,
        MMD_OP_XWR = 7'h20,
        MMD_OP_JMP = 7'h40
    } mmd_op_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mmd_sfr_s;

    typedef struct packed {
        logic [15:0] dp0;
        logic [15:0] dp1;
        logic sel;
    } mmd_ptr_s;
endpackage

// ==== logic/mmd_aux_ram.sv ====
// Purpose: auxiliary ram storage with range and enable gating
// Assumes: address already formed by caller
// Notes: out-of-range or disabled accesses leave storage alone
`timescale 1ns/1ps
module mmd_aux_ram #(
    parameter int DEPTH = mmd_pkg::AUX_BYTES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    initial begin
        if (DEPTH < 1 || DEPTH > 65536) $error("mmd_aux_ram: bad depth");
    end

    logic [7:0] mem [DEPTH];
    logic [7:0] rdata_reg;
    logic hit;

    assign hit = en && ({16'h0000, addr} < 32'(DEPTH)); // [R11] [R24]

    always_ff @(posedge clk) begin
        if (wr && hit) begin
            mem[addr[$clog2(DEPTH)-1:0]] <= wdata; // [R24]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= mmd_pkg::RST_BYTE;
        end else if (rd) begin
            rdata_reg <= hit ? mem[addr[$clog2(DEPTH)-1:0]] : mmd_pkg::RST_BYTE; // [R24]
        end
    end

    assign rdata = rdata_reg;
endmodule // mmd_aux_ram

// ==== logic/mmd_iram.sv ====
// Purpose: 256-byte internal data ram
// Assumes: caller resolves direct versus indirect addressing
// Notes: upper half is reached only via the indirect port path
`timescale 1ns/1ps
module mmd_iram #(
    parameter int DEPTH = mmd_pkg::IRAM_BYTES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    initial begin
        if (DEPTH != 256) $error("mmd_iram: depth must be 256");
    end

    logic [7:0] mem [DEPTH];
    logic [7:0] rdata_reg;

    always_ff @(posedge clk) begin
        if (wr) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= mmd_pkg::RST_BYTE;
        end else if (rd) begin
            rdata_reg <= mem[addr];
        end
    end

    assign rdata = rdata_reg;
endmodule // mmd_iram

// ==== logic/mmd_memory_map.sv ====
// Purpose: memory map decode and dual data pointer for the cpu core
// Assumes: cpu decode logic drives one op per cycle on the cpu clock
// Notes: no external bus exists; code and aux traffic stays on chip
`timescale 1ns/1ps

// How it works
// (R1) fetches only from 16K code, 0000h-3FFFh
// (R2) no off-chip bus is ever driven
// (R3) upper ram only by indirect addressing
// (R4) lower ram by direct or indirect
// (R5) direct 80h-FFh goes to special registers
// (R6) status bits 4,3 choose one of four banks
// (R7) working register address is bank*8 plus index
// (R8) bytes 20h-2Fh are bit addressable
// (R9) eight-bit indirect aux move reaches 256 bytes
// (R10) pointer aux move reaches all 320 bytes
// (R11) control bit 4 low disables aux ram
// (R12) aux access leaves port3 bit7 untouched
// (R13) two 16-bit pointers, all reset zero
// (R14) select bit 0 chooses active pointer
// (R15) select bits 7-1 ignore writes, read zero
// (R16) incrementing select toggles active pointer
// (R17) pointer ops use only selected pointer
// (R18) software selects pointer before pointer ops
// (R19) pointer increment carries across both bytes
// (R20) immediate load writes both active bytes
// (R21) code read fetches active pointer plus accumulator
// (R22) pointer aux move reads or writes accumulator
// (R23) indirect jump loads pointer plus accumulator
// (R24) bad pointer aux access writes nothing, reads zero
module mmd_memory_map #(
    parameter int CODE_DEPTH = mmd_pkg::CODE_BYTES,
    parameter int AUX_DEPTH = mmd_pkg::AUX_BYTES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire mmd_pkg::mmd_sfr_s sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    input wire mmd_pkg::mmd_op_e ptr_op,
    input wire logic [15:0] load_value,
    input wire logic [7:0] acc,
    output logic [7:0] acc_result,
    output logic acc_result_valid,
    output logic [15:0] jump_target,
    output logic jump_valid,
    input wire logic [15:0] fetch_addr,
    output logic [13:0] code_addr,
    output logic code_fetch_ok,
    input wire logic [7:0] code_rdata,
    input wire logic iram_wr,
    input wire logic iram_rd,
    input wire logic iram_indirect,
    input wire logic [7:0] iram_addr,
    input wire logic [7:0] iram_wdata,
    output logic [7:0] iram_rdata,
    output logic iram_to_sfr,
    input wire logic [7:0] status_word,
    input wire logic [2:0] reg_index,
    output logic [7:0] working_reg_addr,
    input wire logic [7:0] bit_addr,
    output logic [7:0] bit_byte_addr,
    output logic [2:0] bit_pos,
    input wire logic aux_ri_wr,
    input wire logic aux_ri_rd,
    input wire logic [7:0] aux_ri_addr,
    input wire logic [7:0] chip_control,
    output logic ext_bus_en,
    output logic port3_bit7_strobe,
    output mmd_pkg::mmd_ptr_s ptr_state
);
    initial begin
        if (CODE_DEPTH != 16384) $error("mmd_memory_map: code depth must be 16384");
        if (AUX_DEPTH < mmd_pkg::AUX_LOW_BYTES) $error("mmd_memory_map: aux too small");
        // the pointer is the whole aux address, so depth stops at its reach
        if (AUX_DEPTH > 2 ** 16) $error("mmd_memory_map: aux beyond pointer reach");
    end

    typedef struct packed {
        mmd_pkg::mmd_ptr_s ptr;
        logic [7:0] sfr_rdata;
        logic sfr_hit;
        logic [7:0] acc_result;
        logic acc_result_valid;
        logic [15:0] jump_target;
        logic jump_valid;
        logic aux_pend;
    } mmd_state_s;

    mmd_state_s st_reg;
    mmd_state_s st_next;

    // one-hot slots of the pointer registers on the special register bus
    localparam logic [4:0] SLOT_NONE = 5'h00;
    localparam logic [4:0] SLOT_DP0_LOW = 5'h01;
    localparam logic [4:0] SLOT_DP0_HIGH = 5'h02;
    localparam logic [4:0] SLOT_DP1_LOW = 5'h04;
    localparam logic [4:0] SLOT_DP1_HIGH = 5'h08;
    localparam logic [4:0] SLOT_PTR_SEL = 5'h10;

    logic [15:0] active_pointer;
    logic [15:0] code_sum;
    logic aux_wr;
    logic aux_rd;
    logic [15:0] aux_addr;
    logic [7:0] aux_rdata;
    logic aux_en;
    logic direct_upper;
    logic [4:0] sfr_slot_oh;

    function automatic logic [15:0] ptr_pick(input mmd_pkg::mmd_ptr_s p);
        ptr_pick = p.sel ? p.dp1 : p.dp0; // [R14] [R17]
    endfunction

    function automatic logic [15:0] ptr_plus_acc(input logic [15:0] p, input logic [7:0] a);
        ptr_plus_acc = p + {8'h00, a};
    endfunction

    // carry runs through both bytes of the pointer
    function automatic logic [15:0] ptr_step(input logic [15:0] p);
        ptr_step = p + 16'h0001; // [R19]
    endfunction

    // read and write share one decode so the two can never disagree
    function automatic logic [4:0] sfr_slot(input logic [7:0] a);
        if (a == mmd_pkg::OFS_DP0_LOW) begin
            sfr_slot = SLOT_DP0_LOW;
        end else if (a == mmd_pkg::OFS_DP0_HIGH) begin
            sfr_slot = SLOT_DP0_HIGH;
        end else if (a == mmd_pkg::OFS_DP1_LOW) begin
            sfr_slot = SLOT_DP1_LOW;
        end else if (a == mmd_pkg::OFS_DP1_HIGH) begin
            sfr_slot = SLOT_DP1_HIGH;
        end else if (a == mmd_pkg::OFS_PTR_SEL) begin
            sfr_slot = SLOT_PTR_SEL;
        end else begin
            sfr_slot = SLOT_NONE;
        end
    endfunction

    assign active_pointer = ptr_pick(st_reg.ptr);
    assign code_sum = ptr_plus_acc(active_pointer, acc); // [R21]
    assign aux_en = chip_control[mmd_pkg::AUX_EN_BIT]; // [R11]
    assign sfr_slot_oh = sfr_slot(sfr_req.addr);

    // code fetch path, only the 14-bit on-chip range decodes
    always_comb begin
        if (ptr_op == mmd_pkg::MMD_OP_CODE) begin
            code_addr = code_sum[13:0]; // [R21]
            code_fetch_ok = (code_sum <= mmd_pkg::CODE_LAST); // [R1]
        end else begin
            code_addr = fetch_addr[13:0]; // [R1]
            code_fetch_ok = (fetch_addr <= mmd_pkg::CODE_LAST); // [R1]
        end
    end

    // no external memory port; these stay idle forever
    assign ext_bus_en = 1'b0; // [R2]
    assign port3_bit7_strobe = 1'b0; // [R12]

    // direct upper addresses belong to the special registers
    assign direct_upper = !iram_indirect && (iram_addr >= mmd_pkg::IRAM_UPPER_BASE); // [R3] [R5]
    assign iram_to_sfr = direct_upper; // [R5]

    // bank base from status bits, register index low
    assign working_reg_addr = {3'h0, status_word[mmd_pkg::BANK_HI_BIT],
        status_word[mmd_pkg::BANK_LO_BIT], reg_index}; // [R6] [R7]

    // bit addresses 00h-7Fh map into bytes 20h-2Fh
    assign bit_byte_addr = mmd_pkg::BIT_AREA_BASE + {4'h0, bit_addr[6:3]}; // [R8]
    assign bit_pos = bit_addr[2:0]; // [R8]

    // pointer moves take priority over 8-bit indirect moves
    always_comb begin
        if (ptr_op == mmd_pkg::MMD_OP_XRD || ptr_op == mmd_pkg::MMD_OP_XWR) begin
            aux_addr = active_pointer; // [R10] [R22]
            aux_wr = (ptr_op == mmd_pkg::MMD_OP_XWR);
            aux_rd = (ptr_op == mmd_pkg::MMD_OP_XRD);
        end else begin
            aux_addr = {8'h00, aux_ri_addr}; // [R9]
            aux_wr = aux_ri_wr;
            aux_rd = aux_ri_rd;
        end
    end

    mmd_aux_ram #(
        .DEPTH(AUX_DEPTH)
    ) u_aux (
        .clk(clk),
        .rst_n(rst_n),
        .en(aux_en),
        .wr(aux_wr),
        .rd(aux_rd),
        .addr(aux_addr),
        .wdata(acc), // [R22]
        .rdata(aux_rdata)
    );

    mmd_iram u_iram (
        .clk(clk),
        .rst_n(rst_n),
        .wr(iram_wr && !direct_upper), // [R3] [R4]
        .rd(iram_rd && !direct_upper), // [R4]
        .addr(iram_addr),
        .wdata(iram_wdata),
        .rdata(iram_rdata)
    );

    always_comb begin
        st_next = st_reg;
        st_next.sfr_hit = 1'b0;
        st_next.acc_result_valid = 1'b0;
        st_next.jump_valid = 1'b0;
        st_next.aux_pend = 1'b0;
        // aux read data lands one edge after the ram samples it
        if (st_reg.aux_pend) begin
            st_next.acc_result = aux_rdata; // [R22] [R24]
            st_next.acc_result_valid = 1'b1;
        end
        // special register reads
        if (sfr_req.rd) begin
            if (sfr_slot_oh == SLOT_DP0_LOW) begin
                st_next.sfr_rdata = st_reg.ptr.dp0[7:0];
                st_next.sfr_hit = 1'b1;
            end else if (sfr_slot_oh == SLOT_DP0_HIGH) begin
                st_next.sfr_rdata = st_reg.ptr.dp0[15:8];
                st_next.sfr_hit = 1'b1;
            end else if (sfr_slot_oh == SLOT_DP1_LOW) begin
                st_next.sfr_rdata = st_reg.ptr.dp1[7:0];
                st_next.sfr_hit = 1'b1;
            end else if (sfr_slot_oh == SLOT_DP1_HIGH) begin
                st_next.sfr_rdata = st_reg.ptr.dp1[15:8];
                st_next.sfr_hit = 1'b1;
            end else if (sfr_slot_oh == SLOT_PTR_SEL) begin
                st_next.sfr_rdata = {7'h00, st_reg.ptr.sel}; // [R15]
                st_next.sfr_hit = 1'b1;
            end else begin
                st_next.sfr_rdata = mmd_pkg::RST_BYTE;
            end
        end
        // special register writes; upper select bits are dropped
        if (sfr_req.wr) begin
            if (sfr_slot_oh == SLOT_DP0_LOW) begin
                st_next.ptr.dp0[7:0] = sfr_req.wdata;
            end else if (sfr_slot_oh == SLOT_DP0_HIGH) begin
                st_next.ptr.dp0[15:8] = sfr_req.wdata;
            end else if (sfr_slot_oh == SLOT_DP1_LOW) begin
                st_next.ptr.dp1[7:0] = sfr_req.wdata;
            end else if (sfr_slot_oh == SLOT_DP1_HIGH) begin
                st_next.ptr.dp1[15:8] = sfr_req.wdata;
            end else if (sfr_slot_oh == SLOT_PTR_SEL) begin
                st_next.ptr.sel = sfr_req.wdata[mmd_pkg::SEL_BIT]; // [R14] [R15] [R16]
            end
        end
        // pointer ops win over a same-cycle register write
        case (ptr_op)
            mmd_pkg::MMD_OP_INC: begin
                if (st_reg.ptr.sel) begin
                    st_next.ptr.dp1 = ptr_step(st_reg.ptr.dp1); // [R19] [R17]
                end else begin
                    st_next.ptr.dp0 = ptr_step(st_reg.ptr.dp0); // [R19] [R17]
                end
            end
            mmd_pkg::MMD_OP_LOAD: begin
                if (st_reg.ptr.sel) begin
                    st_next.ptr.dp1 = load_value; // [R20]
                end else begin
                    st_next.ptr.dp0 = load_value; // [R20]
                end
            end
            mmd_pkg::MMD_OP_CODE: begin
                // code byte only matches code_addr while this op stands
                st_next.acc_result = code_rdata; // [R21]
                st_next.acc_result_valid = 1'b1;
            end
            mmd_pkg::MMD_OP_XRD: begin
                st_next.aux_pend = 1'b1; // [R22]
            end
            mmd_pkg::MMD_OP_JMP: begin
                st_next.jump_target = code_sum; // [R23]
                st_next.jump_valid = 1'b1;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0; // [R13]
        end else begin
            st_reg <= st_next;
        end
    end

    assign sfr_rdata = st_reg.sfr_rdata;
    assign sfr_hit = st_reg.sfr_hit;
    assign acc_result = st_reg.acc_result;
    assign acc_result_valid = st_reg.acc_result_valid;
    assign jump_target = st_reg.jump_target;
    assign jump_valid = st_reg.jump_valid;
    assign ptr_state = st_reg.ptr;
endmodule // mmd_memory_map

// ==== tb/mmd_code_rom.sv ====
// Purpose: code memory stand-in on the far side of the fetch path
// Assumes: answers in the same cycle as the address
// Notes: pattern folds the high bits in, so a wrong bank shows
`timescale 1ns/1ps
module mmd_code_rom (
    input wire logic [13:0] code_addr,
    output logic [7:0] code_rdata
);
    assign code_rdata = code_addr[7:0] ^ {2'h0, code_addr[13:8]} ^ 8'h5a;
endmodule // mmd_code_rom

// ==== tb/mmd_memory_map_chk.sv ====
// Purpose: port checks for the memory map block
// Assumes: one clock, async active-low reset
// Notes: increments with a same-cycle sfr write are left out of the increment check
`timescale 1ns/1ps
module mmd_memory_map_chk #(
    parameter int CODE_DEPTH = 16384
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire mmd_pkg::mmd_sfr_s sfr_req,
    input wire mmd_pkg::mmd_op_e ptr_op,
    input wire logic [7:0] acc,
    input wire logic [7:0] acc_result,
    input wire logic acc_result_valid,
    input wire logic [15:0] jump_target,
    input wire logic jump_valid,
    input wire logic [15:0] fetch_addr,
    input wire logic [13:0] code_addr,
    input wire logic code_fetch_ok,
    input wire logic [7:0] code_rdata,
    input wire logic iram_wr,
    input wire logic iram_rd,
    input wire logic iram_indirect,
    input wire logic [7:0] iram_addr,
    input wire logic iram_to_sfr,
    input wire logic [7:0] status_word,
    input wire logic [2:0] reg_index,
    input wire logic [7:0] working_reg_addr,
    input wire logic [7:0] bit_addr,
    input wire logic [7:0] bit_byte_addr,
    input wire logic [2:0] bit_pos,
    input wire logic ext_bus_en,
    input wire logic port3_bit7_strobe,
    input wire mmd_pkg::mmd_ptr_s ptr_state
);
    logic [15:0] act;
    assign act = ptr_state.sel ? ptr_state.dp1 : ptr_state.dp0;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_code_addr;
        code_addr == act[13:0] + {6'h00, acc};
    endsequence
    sequence s_code_ans;
        acc_result_valid && acc_result == $past(code_rdata);
    endsequence
    AST_NO_OFFCHIP: assert property (!ext_bus_en && !port3_bit7_strobe)
        else $error("off-chip strobe driven");
    AST_FETCH_RANGE: assert property (ptr_op != mmd_pkg::MMD_OP_CODE |->
        code_fetch_ok == (fetch_addr < CODE_DEPTH)) else $error("fetch range wrong");
    AST_BANK_ADDR: assert property (working_reg_addr ==
        {3'h0, status_word[4:3], reg_index}) else $error("bank address wrong");
    AST_BIT_AREA: assert property (!bit_addr[7] |-> bit_pos == bit_addr[2:0] &&
        bit_byte_addr == 8'h20 + {4'h0, bit_addr[6:3]}) else $error("bit map wrong");
    AST_DIRECT_UPPER: assert property ((iram_wr || iram_rd) |->
        iram_to_sfr == (!iram_indirect && iram_addr[7])) else $error("sfr route wrong");
    AST_PTR_INC: assert property (ptr_op == mmd_pkg::MMD_OP_INC && !sfr_req.wr
        |=> act == $past(act) + 16'h0001) else $error("increment wrong");
    AST_JUMP: assert property (ptr_op == mmd_pkg::MMD_OP_JMP |=> jump_valid &&
        jump_target == $past(act) + {8'h00, $past(acc)}) else $error("jump target wrong");
    AST_CODE_READ: assert property (ptr_op == mmd_pkg::MMD_OP_CODE |->
        s_code_addr ##1 s_code_ans) else $error("code read wrong");
endmodule // mmd_memory_map_chk
bind mmd_memory_map mmd_memory_map_chk #(.CODE_DEPTH(CODE_DEPTH)) chk_u (.clk, .rst_n,
    .sfr_req, .ptr_op, .acc, .acc_result, .acc_result_valid, .jump_target, .jump_valid,
    .fetch_addr, .code_addr, .code_fetch_ok, .code_rdata, .iram_wr, .iram_rd,
    .iram_indirect, .iram_addr, .iram_to_sfr, .status_word, .reg_index, .working_reg_addr,
    .bit_addr, .bit_byte_addr, .bit_pos, .ext_bus_en, .port3_bit7_strobe, .ptr_state);

// ==== tb/mmd_memory_map_tb.sv ====
// Purpose: directed bench for memory map and dual pointer
// Assumes: inputs change by nba at the rising edge
// Notes: results sampled 1 ns after the edge that makes them
`timescale 1ns/1ps
module mmd_memory_map_tb;
    logic clk, rst_n, sfr_hit, acc_result_valid, jump_valid, code_fetch_ok, iram_wr;
    logic iram_rd, iram_indirect, iram_to_sfr, aux_ri_wr, aux_ri_rd, ext_bus_en;
    logic port3_bit7_strobe;
    logic [15:0] load_value, jump_target, fetch_addr;
    logic [13:0] code_addr;
    logic [7:0] acc, acc_result, code_rdata, iram_addr, iram_wdata, iram_rdata, sfr_rdata;
    logic [7:0] status_word, working_reg_addr, bit_addr, bit_byte_addr, aux_ri_addr;
    logic [7:0] chip_control;
    logic [2:0] reg_index, bit_pos;
    mmd_pkg::mmd_sfr_s sfr_req;
    mmd_pkg::mmd_op_e ptr_op;
    mmd_pkg::mmd_ptr_s ptr_state;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;
    mmd_memory_map dut_u (.clk, .rst_n, .sfr_req, .sfr_rdata, .sfr_hit, .ptr_op, .load_value,
        .acc, .acc_result, .acc_result_valid, .jump_target, .jump_valid, .fetch_addr,
        .code_addr, .code_fetch_ok, .code_rdata, .iram_wr, .iram_rd, .iram_indirect,
        .iram_addr, .iram_wdata, .iram_rdata, .iram_to_sfr, .status_word, .reg_index,
        .working_reg_addr, .bit_addr, .bit_byte_addr, .bit_pos, .aux_ri_wr, .aux_ri_rd,
        .aux_ri_addr, .chip_control, .ext_bus_en, .port3_bit7_strobe, .ptr_state);
    mmd_code_rom rom_u (.code_addr, .code_rdata);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic finish_test;
        $display("mismatches %0d of %0d checks", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // hang guard: the whole run needs well under 400 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            finish_test();
        end
    end
    task automatic cmp_w(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmp_b(input logic [7:0] got, input logic [7:0] exp);
        cmp_w({8'h00, got}, {8'h00, exp});
    endtask
    task automatic sfr(input logic rd, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_req <= '{~rd, rd, a, d};
        @(posedge clk);
        sfr_req <= '0;
        #1;
    endtask
    task automatic op(input mmd_pkg::mmd_op_e o, input logic [15:0] v, input logic [7:0] a);
        @(posedge clk);
        ptr_op <= o;
        load_value <= v;
        acc <= a;
        @(posedge clk);
        ptr_op <= mmd_pkg::MMD_OP_NONE;
        #1;
    endtask
    // aux read answers on the second edge
    task automatic xrd(input logic [7:0] exp);
        op(mmd_pkg::MMD_OP_XRD, 16'h0000, 8'h00);
        @(posedge clk);
        #1;
        cmp_b(8'(acc_result_valid), 8'h01);
        cmp_b(acc_result, exp);
    endtask
    task automatic ram(input logic w, input logic ind, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {iram_wr, iram_rd, iram_indirect, iram_addr, iram_wdata} <= {w, ~w, ind, a, d};
        #1;
        cmp_b(8'(iram_to_sfr), 8'(~ind & a[7]));
        @(posedge clk);
        {iram_wr, iram_rd} <= 2'b00;
        #1;
    endtask
    initial begin
        rst_n = 1'b0;
        sfr_req = '0;
        ptr_op = mmd_pkg::MMD_OP_NONE;
        {load_value, fetch_addr, acc, iram_addr, iram_wdata, status_word, bit_addr} = '0;
        {iram_wr, iram_rd, iram_indirect, aux_ri_wr, aux_ri_rd, reg_index} = '0;
        {aux_ri_addr, chip_control} = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 8'h82; a <= 8'h86; a++) begin
            sfr(1'b1, 8'(a), 8'h00);
            cmp_b(sfr_rdata, 8'h00);
            cmp_b(8'(sfr_hit), 8'h01);
        end
        sfr(1'b0, 8'h86, 8'hff);
        sfr(1'b1, 8'h86, 8'h00);
        cmp_b(sfr_rdata, 8'h01);
        cmp_b(8'(sfr_hit), 8'h01);
        sfr(1'b0, 8'h82, 8'h34);
        sfr(1'b0, 8'h83, 8'h12);
        op(mmd_pkg::MMD_OP_LOAD, 16'h00ff, 8'h00);
        cmp_w(ptr_state.dp1, 16'h00ff);
        cmp_w(ptr_state.dp0, 16'h1234);
        op(mmd_pkg::MMD_OP_INC, 16'h0000, 8'h00);
        cmp_w(ptr_state.dp1, 16'h0100);
        sfr(1'b1, 8'h85, 8'h00);
        cmp_b(sfr_rdata, 8'h01);
        sfr(1'b1, 8'h86, 8'h00);
        cmp_b(sfr_rdata, 8'h01);
        sfr(1'b0, 8'h86, sfr_rdata + 8'h01);
        op(mmd_pkg::MMD_OP_JMP, 16'h0000, 8'hf0);
        cmp_b(8'(jump_valid), 8'h01);
        cmp_w(jump_target, 16'h1324);
        op(mmd_pkg::MMD_OP_CODE, 16'h0000, 8'h10);
        cmp_b(8'(acc_result_valid), 8'h01);
        cmp_b(acc_result, 8'h44 ^ 8'h12 ^ 8'h5a);
        @(posedge clk);
        chip_control <= 8'h10;
        sfr(1'b0, 8'h86, 8'h01);
        op(mmd_pkg::MMD_OP_LOAD, 16'h013f, 8'h00);
        op(mmd_pkg::MMD_OP_XWR, 16'h0000, 8'ha5);
        xrd(8'ha5);
        op(mmd_pkg::MMD_OP_LOAD, 16'h0140, 8'h00);
        op(mmd_pkg::MMD_OP_XWR, 16'h0000, 8'h3c);
        xrd(8'h00);
        op(mmd_pkg::MMD_OP_LOAD, 16'h013f, 8'h00);
        @(posedge clk);
        chip_control <= 8'hef;
        op(mmd_pkg::MMD_OP_XWR, 16'h0000, 8'h77);
        xrd(8'h00);
        @(posedge clk);
        chip_control <= 8'h10;
        xrd(8'ha5);
        @(posedge clk);
        {aux_ri_wr, aux_ri_addr, acc} <= {1'b1, 8'hff, 8'hc3};
        @(posedge clk);
        aux_ri_wr <= 1'b0;
        op(mmd_pkg::MMD_OP_LOAD, 16'h00ff, 8'h00);
        xrd(8'hc3);
        ram(1'b1, 1'b0, 8'h10, 8'h11);
        ram(1'b0, 1'b1, 8'h10, 8'h00);
        cmp_b(iram_rdata, 8'h11);
        ram(1'b1, 1'b1, 8'h90, 8'h22);
        ram(1'b1, 1'b0, 8'h90, 8'h33);
        ram(1'b0, 1'b1, 8'h90, 8'h00);
        cmp_b(iram_rdata, 8'h22);
        for (int b = 0; b < 4; b++) begin
            @(posedge clk);
            status_word <= 8'(b << 3) | 8'he7;
            reg_index <= 3'(b + 1);
            bit_addr <= 8'(b * 37);
            fetch_addr <= 16'h3ffe + 16'(b);
            #1;
            cmp_b(working_reg_addr, 8'(b * 8 + b + 1));
            cmp_b(bit_byte_addr, 8'(32 + b * 37 / 8));
            cmp_b(8'(bit_pos), 8'(b * 37 % 8));
            cmp_b(8'(code_fetch_ok), 8'(b < 2));
            cmp_b(8'({ext_bus_en, port3_bit7_strobe}), 8'h00);
        end
        // mid-run reset must clear pointers that hold live values
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        cmp_w(ptr_state.dp0, 16'h0000);
        cmp_w(ptr_state.dp1, 16'h0000);
        cmp_b(8'(ptr_state.sel), 8'h00);
        finish_test();
    end
endmodule // mmd_memory_map_tb
